// File: test/pce_pins_model.sv
`timescale 1ns/10ps
// external pin drivers; levels move only when the bench asks
module pce_pins_model
(
  output logic [pce_pkg::PA_W-1:0] port_a_o,
  output logic [pce_pkg::PB_W-1:0] port_b_o
);
  import pce_pkg::*;

  // pins start low so reset shows no edge
  initial
  begin
    port_a_o = '0;
    port_b_o = '0;
  end

  // called right after a rising edge, so nba keeps it race free
  task automatic drive(input logic [PA_W-1:0] a, input logic [PB_W-1:0] b);
    port_a_o <= a;
    port_b_o <= b;
  endtask
endmodule // pce_pins_model

// File: test/pce_top_tb.sv
`timescale 1ns/10ps
module pce_top_tb;
  import pce_pkg::*;
  logic              clk_i = 1'b0;
  logic              rst_i = 1'b1;
  logic              ce_i  = 1'b1;
  pce_apb_req_t      req   = '0;
  logic [APB_DW-1:0] prdata_o;
  logic              pready_o;
  logic              pslverr_o;
  logic              irq_o;
  logic              wake_o;
  logic              summary_o;
  logic [PA_W-1:0]   pa;
  logic [PB_W-1:0]   pb;
  logic [31:0]       rd;
  logic              err;
  int                error_cnt  = 0;
  int                num_checks = 0;

  always #20 clk_i = ~clk_i;

  pce_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .apb_req_i(req), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .port_a_a_i(pa), .port_b_b_i(pb),
    .irq_o(irq_o), .wake_o(wake_o), .summary_o(summary_o));
  pce_pins_model u_pins (.port_a_o(pa), .port_b_o(pb));

  task automatic chk(input string nm, input logic [31:0] got, exp);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // one apb transfer; an idle cycle after it avoids double drive of req
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    req <= '{psel:1'b1, penable:1'b0, pwrite:w, paddr:a, pwdata:d};
    @(posedge clk_i);
    req.penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    if (n >= 20) chk("pready", 0, 1);
    rd = prdata_o;
    err = pslverr_o;
    req <= '0;
    @(posedge clk_i);
  endtask

  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, rd, e);
  endtask

  // clear only the flags seen set; an edge between the reads survives
  task automatic sw_clear(input logic [7:0] a);
    logic [31:0] keep;
    apb(1'b0, a, 32'h0);
    keep = rd ^ 32'hff;
    apb(1'b0, a, 32'h0);
    apb(1'b1, a, rd & keep);
  endtask

  // every register zero after reset, unmapped place refused
  task automatic t_reset;
    logic [7:0] offs [9] = '{OFF_A_RISE, OFF_A_FALL, OFF_A_FLAG, OFF_B_RISE,
      OFF_B_FALL, OFF_B_FLAG, OFF_CTRL, OFF_EV_STS, OFF_EV_MSK};
    foreach (offs[i]) rdchk("reset value", offs[i], 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped err", {31'h0, err}, 32'h1);
    chk("unmapped data", rd, 32'h0);
  endtask

  // all ones written, only implemented enable bits stick
  task automatic t_regs;
    logic [7:0]  offs [4] = '{OFF_A_RISE, OFF_A_FALL, OFF_B_RISE, OFF_B_FALL};
    logic [31:0] exps [4] = '{32'h3f, 32'h3f, 32'hf0, 32'hf0};
    foreach (offs[i])
    begin
      apb(1'b1, offs[i], 32'hffffffff);
      rdchk("enable bits", offs[i], exps[i]);
    end
  endtask

  // pin0 rise only, pin1 fall only, pin2 both; port b pin4 rise, pin5 fall
  task automatic t_edges;
    apb(1'b1, OFF_A_RISE, 32'h05);
    apb(1'b1, OFF_A_FALL, 32'h06);
    apb(1'b1, OFF_B_RISE, 32'h10);
    apb(1'b1, OFF_B_FALL, 32'h20);
    u_pins.drive(6'h3f, 4'hf);
    repeat (4) @(posedge clk_i);
    rdchk("a rise flags", OFF_A_FLAG, 32'h05);
    rdchk("b rise flags", OFF_B_FLAG, 32'h10);
    apb(1'b1, OFF_A_FLAG, 32'h0);
    rdchk("a cleared", OFF_A_FLAG, 32'h0);
    u_pins.drive(6'h00, 4'h0);
    repeat (4) @(posedge clk_i);
    rdchk("a fall flags", OFF_A_FLAG, 32'h06);
    rdchk("b flag sticky", OFF_B_FLAG, 32'h30);
  endtask

  // flags held while master enable off, then enable and mask
  task automatic t_irq;
    chk("summary", {31'h0, summary_o}, 32'h1);
    chk("irq off", {31'h0, irq_o}, 32'h0);
    chk("wake off", {31'h0, wake_o}, 32'h0);
    apb(1'b1, OFF_CTRL, 32'h1);
    repeat (2) @(posedge clk_i);
    chk("masked irq", {31'h0, irq_o}, 32'h0);
    chk("wake on", {31'h0, wake_o}, 32'h1);
    apb(1'b1, OFF_EV_MSK, 32'h3);
    repeat (2) @(posedge clk_i);
    chk("irq on", {31'h0, irq_o}, 32'h1);
    rdchk("ctrl", OFF_CTRL, 32'h3);
    // clear by masking only the bits seen set
    sw_clear(OFF_A_FLAG);
    sw_clear(OFF_B_FLAG);
    apb(1'b1, OFF_EV_STS, 32'h3);
    repeat (2) @(posedge clk_i);
    chk("irq cleared", {31'h0, irq_o}, 32'h0);
    chk("summary clr", {31'h0, summary_o}, 32'h0);
    chk("wake clr", {31'h0, wake_o}, 32'h0);
    rdchk("ev status", OFF_EV_STS, 32'h0);
  endtask

  // edge lands on the very edge that stores a zero write
  task automatic t_race;
    apb(1'b1, OFF_A_FLAG, 32'h01);
    fork
      apb(1'b1, OFF_A_FLAG, 32'h0);
      u_pins.drive(6'h04, 4'h0);
    join
    rdchk("set beats clear", OFF_A_FLAG, 32'h04);
  endtask

  // clock enable low freezes detection; the edge lands once it returns
  task automatic t_hold;
    apb(1'b1, OFF_A_FLAG, 32'h0);
    ce_i <= 1'b0;
    u_pins.drive(6'h00, 4'h0);
    repeat (6) @(posedge clk_i);
    chk("frozen summary", {31'h0, summary_o}, 32'h0);
    ce_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    chk("resumed summary", {31'h0, summary_o}, 32'h1);
    rdchk("resumed flags", OFF_A_FLAG, 32'h04);
  endtask

  // reset in mid-run returns every enable and flag to zero
  task automatic t_rerun;
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rdchk("rerun flags", OFF_A_FLAG, 32'h0);
    rdchk("rerun enables", OFF_B_RISE, 32'h0);
    chk("rerun irq", {31'h0, irq_o}, 32'h0);
  endtask

  task automatic close_out;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // main sequence
  initial
  begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset;
    t_regs;
    t_edges;
    t_irq;
    t_race;
    t_hold;
    t_rerun;
    close_out;
  end

  // whole run needs a few hundred cycles; 5000 means a hang
  initial
  begin
    #200000;
    error_cnt++;
    close_out;
  end
endmodule // pce_top_tb

// File: verilog/pce_pkg.sv
package pce_pkg;

  // apb geometry
  localparam int unsigned APB_AW = 8;
  localparam int unsigned APB_DW = 32;

  // pin counts; port b pins occupy register bits 7:4
  localparam int unsigned PA_W   = 6;
  localparam int unsigned PB_W   = 4;
  localparam int unsigned PB_LSB = 4;
  localparam int unsigned EV_W   = 2;

  // register byte offsets
  localparam logic [APB_AW-1:0] OFF_A_RISE = 8'h00;
  localparam logic [APB_AW-1:0] OFF_A_FALL = 8'h04;
  localparam logic [APB_AW-1:0] OFF_A_FLAG = 8'h08;
  localparam logic [APB_AW-1:0] OFF_B_RISE = 8'h0c;
  localparam logic [APB_AW-1:0] OFF_B_FALL = 8'h10;
  localparam logic [APB_AW-1:0] OFF_B_FLAG = 8'h14;
  localparam logic [APB_AW-1:0] OFF_CTRL   = 8'h18;
  localparam logic [APB_AW-1:0] OFF_EV_STS = 8'h1c;
  localparam logic [APB_AW-1:0] OFF_EV_MSK = 8'h20;

  // control register fields
  localparam int unsigned CTRL_IEN_BIT = 0;
  localparam int unsigned CTRL_SUM_BIT = 1;

  // event status / mask fields
  localparam int unsigned EV_A_BIT = 0;
  localparam int unsigned EV_B_BIT = 1;

  // reset values
  localparam logic [PA_W-1:0] RST_A = 6'h00;
  localparam logic [PB_W-1:0] RST_B = 4'h0;
  localparam logic [EV_W-1:0] RST_EV = 2'h0;

  // apb request from the master
  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [APB_AW-1:0] paddr;
    logic [APB_DW-1:0] pwdata;
  } pce_apb_req_t;

  // whole block state
  typedef struct packed {
    logic [PA_W-1:0]   a_s1;
    logic [PA_W-1:0]   a_s2;
    logic [PA_W-1:0]   a_prev;
    logic [PB_W-1:0]   b_s1;
    logic [PB_W-1:0]   b_s2;
    logic [PB_W-1:0]   b_prev;
    logic [PA_W-1:0]   a_rise;
    logic [PA_W-1:0]   a_fall;
    logic [PA_W-1:0]   a_flag;
    logic [PB_W-1:0]   b_rise;
    logic [PB_W-1:0]   b_fall;
    logic [PB_W-1:0]   b_flag;
    logic              ien;
    logic [EV_W-1:0]   ev_sts;
    logic [EV_W-1:0]   ev_msk;
    logic              pready;
    logic              pslverr;
    logic [APB_DW-1:0] prdata;
    logic              irq;
    logic              wake;
    logic              summary;
  } pce_state_t;

endpackage

// File: verilog/pce_top.sv
`timescale 1ns/10ps
// Behaviour
// - each pin has a rising detector, active while its rise enable bit is one
// - each pin has a falling detector, active while its fall enable bit is one
// - both enables set means both edge directions are detected together
// - an enabled edge sets the pin flag, which stays until software clears
// - interrupt from a set flag only while master enable is one
// - master enable zero still detects and flags, but raises no interrupt
// - summary flag is the OR of all implemented pin flags
// - writing zero to a flag bit clears that flag
// - an edge during a flag write leaves the flag set regardless of data
// - a pin-change event wakes from sleep while master enable is one
// - an edge in sleep updates flags before the core resumes
// - port a rise enable holds bits 5:0, bits 7:6 read zero
// - port a fall enable holds bits 5:0, bits 7:6 read zero
// - port a flags set by enabled rising or falling edges
// - port b enables hold bits 7:4 only, bits 3:0 read zero
// - all enable and flag bits reset to zero
module pce_top
(
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  input  wire logic                     ce_i,
  input  wire pce_pkg::pce_apb_req_t    apb_req_i,
  output logic [pce_pkg::APB_DW-1:0]    prdata_o,
  output logic                          pready_o,
  output logic                          pslverr_o,
  input  wire logic [pce_pkg::PA_W-1:0] port_a_a_i,
  input  wire logic [pce_pkg::PB_W-1:0] port_b_b_i,
  output logic                          irq_o,
  output logic                          wake_o,
  output logic                          summary_o
);
  import pce_pkg::*;

  pce_state_t st_r;
  pce_state_t st_nxt;

  logic [PA_W-1:0]   a_rise_ev;
  logic [PA_W-1:0]   a_fall_ev;
  logic [PA_W-1:0]   a_set;
  logic [PB_W-1:0]   b_rise_ev;
  logic [PB_W-1:0]   b_fall_ev;
  logic [PB_W-1:0]   b_set;
  logic              acc_done;
  logic              wr_en;
  logic [APB_DW-1:0] rd_word;
  logic              mapped;

  // single address decode shared by read, write and error paths
  function automatic logic hit(input logic [APB_AW-1:0] addr,
                               input logic [APB_AW-1:0] off);
    hit = (addr == off);
  endfunction

  // per-pin edge detection, one detector per direction
  genvar gi;
  generate
    for (gi = 0; gi < PA_W; gi++)
    begin : g_pa
      assign a_rise_ev[gi] = st_r.a_s2[gi] & ~st_r.a_prev[gi];
      assign a_fall_ev[gi] = ~st_r.a_s2[gi] & st_r.a_prev[gi];
      // either direction may fire, both when both enabled
      assign a_set[gi] = (a_rise_ev[gi] & st_r.a_rise[gi])
                       | (a_fall_ev[gi] & st_r.a_fall[gi]);
    end
    for (gi = 0; gi < PB_W; gi++)
    begin : g_pb
      // index 0 here is pin 4 of the register field
      assign b_rise_ev[gi] = st_r.b_s2[gi] & ~st_r.b_prev[gi];
      assign b_fall_ev[gi] = ~st_r.b_s2[gi] & st_r.b_prev[gi];
      assign b_set[gi] = (b_rise_ev[gi] & st_r.b_rise[gi])
                       | (b_fall_ev[gi] & st_r.b_fall[gi]);
    end
  endgenerate

  // transfer completes on the edge that samples pready high
  assign acc_done = apb_req_i.psel & apb_req_i.penable & st_r.pready;
  assign wr_en    = acc_done & apb_req_i.pwrite;

  // read mux; unimplemented bits read as zero
  always_comb
  begin
    rd_word = '0;
    mapped  = 1'b1;
    if (hit(apb_req_i.paddr, OFF_A_RISE))
      rd_word[PA_W-1:0] = st_r.a_rise;
    else if (hit(apb_req_i.paddr, OFF_A_FALL))
      rd_word[PA_W-1:0] = st_r.a_fall;
    else if (hit(apb_req_i.paddr, OFF_A_FLAG))
      rd_word[PA_W-1:0] = st_r.a_flag;
    else if (hit(apb_req_i.paddr, OFF_B_RISE))
      rd_word[PB_LSB+PB_W-1:PB_LSB] = st_r.b_rise;
    else if (hit(apb_req_i.paddr, OFF_B_FALL))
      rd_word[PB_LSB+PB_W-1:PB_LSB] = st_r.b_fall;
    else if (hit(apb_req_i.paddr, OFF_B_FLAG))
      rd_word[PB_LSB+PB_W-1:PB_LSB] = st_r.b_flag;
    else if (hit(apb_req_i.paddr, OFF_CTRL))
    begin
      rd_word[CTRL_IEN_BIT] = st_r.ien;
      rd_word[CTRL_SUM_BIT] = st_r.summary;
    end
    else if (hit(apb_req_i.paddr, OFF_EV_STS))
      rd_word[EV_W-1:0] = st_r.ev_sts;
    else if (hit(apb_req_i.paddr, OFF_EV_MSK))
      rd_word[EV_W-1:0] = st_r.ev_msk;
    else
      mapped = 1'b0;
  end

  // next-state logic for the whole block
  always_comb
  begin
    st_nxt = st_r;
    // two-flop pin synchronisers, then the previous-sample stage
    st_nxt.a_s1   = port_a_a_i;
    st_nxt.a_s2   = st_r.a_s1;
    st_nxt.a_prev = st_r.a_s2;
    st_nxt.b_s1   = port_b_b_i;
    st_nxt.b_s2   = st_r.b_s1;
    st_nxt.b_prev = st_r.b_s2;

    // one wait state: pready rises in the second access cycle
    // the wait costs a cycle but keeps read data off the comb path
    st_nxt.pready  = apb_req_i.psel & apb_req_i.penable & ~st_r.pready;
    st_nxt.pslverr = 1'b0;
    if (st_nxt.pready)
    begin
      st_nxt.prdata  = apb_req_i.pwrite ? '0 : rd_word;
      st_nxt.pslverr = ~mapped;
    end

    // enable registers
    if (wr_en && hit(apb_req_i.paddr, OFF_A_RISE))
      st_nxt.a_rise = apb_req_i.pwdata[PA_W-1:0];
    if (wr_en && hit(apb_req_i.paddr, OFF_A_FALL))
      st_nxt.a_fall = apb_req_i.pwdata[PA_W-1:0];
    if (wr_en && hit(apb_req_i.paddr, OFF_B_RISE))
      st_nxt.b_rise = apb_req_i.pwdata[PB_LSB+PB_W-1:PB_LSB];
    if (wr_en && hit(apb_req_i.paddr, OFF_B_FALL))
      st_nxt.b_fall = apb_req_i.pwdata[PB_LSB+PB_W-1:PB_LSB];
    if (wr_en && hit(apb_req_i.paddr, OFF_CTRL))
      st_nxt.ien = apb_req_i.pwdata[CTRL_IEN_BIT];
    if (wr_en && hit(apb_req_i.paddr, OFF_EV_MSK))
      st_nxt.ev_msk = apb_req_i.pwdata[EV_W-1:0];

    // flags: a written zero clears, but a same-cycle edge wins
    // the or comes last, so no write can hide an edge
    if (wr_en && hit(apb_req_i.paddr, OFF_A_FLAG))
      st_nxt.a_flag = apb_req_i.pwdata[PA_W-1:0];
    if (wr_en && hit(apb_req_i.paddr, OFF_B_FLAG))
      st_nxt.b_flag = apb_req_i.pwdata[PB_LSB+PB_W-1:PB_LSB];
    st_nxt.a_flag = st_nxt.a_flag | a_set;
    st_nxt.b_flag = st_nxt.b_flag | b_set;

    // event status is write-one-to-clear, set still wins
    if (wr_en && hit(apb_req_i.paddr, OFF_EV_STS))
      st_nxt.ev_sts = st_r.ev_sts & ~apb_req_i.pwdata[EV_W-1:0];
    st_nxt.ev_sts[EV_A_BIT] = st_nxt.ev_sts[EV_A_BIT] | (|a_set);
    st_nxt.ev_sts[EV_B_BIT] = st_nxt.ev_sts[EV_B_BIT] | (|b_set);

    // outputs track the new flags so the summary never lags them
    st_nxt.summary = (|st_nxt.a_flag) | (|st_nxt.b_flag);
    st_nxt.irq  = st_nxt.ien & (|(st_nxt.ev_sts & st_nxt.ev_msk));
    // flags keep updating on the running clock, so they are valid at wake
    st_nxt.wake = st_nxt.ien & st_nxt.summary;
  end

  // state register; ce low freezes everything, including the bus answer
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_r        <= '0;
      // enables, flags and events take their named reset values
      st_r.a_rise <= RST_A;
      st_r.a_fall <= RST_A;
      st_r.a_flag <= RST_A;
      st_r.b_rise <= RST_B;
      st_r.b_fall <= RST_B;
      st_r.b_flag <= RST_B;
      st_r.ev_sts <= RST_EV;
      st_r.ev_msk <= RST_EV;
    end
    else if (ce_i)
      st_r <= st_nxt;
  end

  assign prdata_o  = st_r.prdata;
  assign pready_o  = st_r.pready;
  assign pslverr_o = st_r.pslverr;
  assign irq_o     = st_r.irq;
  assign wake_o    = st_r.wake;
  assign summary_o = st_r.summary;

  // self checks, all off while reset is high
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // a flag write sequence, and a rising edge on pin 0 with its rise enable set
  sequence s_a_clear_wr;
    ce_i && wr_en && hit(apb_req_i.paddr, OFF_A_FLAG);
  endsequence

  sequence s_pin0_rises;
    ce_i && st_r.a_rise[0] ##1 ce_i && st_r.a_rise[0] && a_rise_ev[0];
  endsequence

  rise_sets_flag_a: assert property (
    s_pin0_rises |=> st_r.a_flag[0])
    else $error("enabled rising edge did not set flag");

  fall_sets_flag_a: assert property (
    ce_i && (|(a_fall_ev & st_r.a_fall))
    |=> (|(st_r.a_flag & $past(a_fall_ev & st_r.a_fall))))
    else $error("enabled falling edge did not set flag");

  both_edges_a: assert property (
    ce_i && st_r.a_rise[2] && st_r.a_fall[2]
    && (st_r.a_s2[2] != st_r.a_prev[2]) |=> st_r.a_flag[2])
    else $error("dual-edge pin missed a transition");

  flag_sticky_a: assert property (
    ce_i && !wr_en |=> ((st_r.a_flag & $past(st_r.a_flag))
                        == $past(st_r.a_flag)))
    else $error("flag dropped without a write");

  no_spurious_a: assert property (
    ce_i && !wr_en && a_set == '0 |=> st_r.a_flag == $past(st_r.a_flag))
    else $error("flag changed with no edge or write");

  irq_gated_a: assert property (
    irq_o |-> st_r.ien && (|(st_r.ev_sts & st_r.ev_msk)))
    else $error("interrupt without master enable");

  no_irq_off_a: assert property (
    ce_i && !st_nxt.ien && (|a_set) |=> !irq_o && (|st_r.a_flag))
    else $error("disabled master still interrupted or lost flag");

  summary_or_a: assert property (
    summary_o == ((|st_r.a_flag) | (|st_r.b_flag)))
    else $error("summary flag differs from flag OR");

  clear_zero_a: assert property (
    s_a_clear_wr and (apb_req_i.pwdata[2] == 1'b0) and (a_set[2] == 1'b0)
    |=> !st_r.a_flag[2])
    else $error("written zero did not clear flag");

  set_wins_a: assert property (
    s_a_clear_wr and a_set[2] |=> st_r.a_flag[2])
    else $error("edge lost during flag write");

  wake_link_a: assert property (
    wake_o == (st_r.ien && summary_o))
    else $error("wake does not follow enable and summary");

  unimpl_zero_a: assert property (
    pready_o && !pslverr_o |-> prdata_o[APB_DW-1:PB_LSB+PB_W] == '0)
    else $error("unimplemented high bits read nonzero");

  b_low_zero_a: assert property (
    ce_i && st_nxt.pready && !apb_req_i.pwrite
    && (hit(apb_req_i.paddr, OFF_B_RISE) || hit(apb_req_i.paddr, OFF_B_FALL))
    |=> prdata_o[PB_LSB-1:0] == '0)
    else $error("port b low bits read nonzero");

  reset_zero_a: assert property (@(posedge clk_i)
    $past(rst_i) |-> st_r.a_flag == '0 && st_r.a_rise == '0
                     && st_r.a_fall == '0 && st_r.b_rise == '0
                     && st_r.b_fall == '0 && st_r.ev_sts == '0
                     && st_r.b_flag == '0 && !irq_o)
    else $error("state not zero after reset");

  edge_delay_a: assert property (
    ce_i && st_r.a_rise[0] && !port_a_a_i[0] ##1 ce_i && port_a_a_i[0]
    ##1 ce_i ##1 ce_i && st_r.a_rise[0] |=> st_r.a_flag[0])
    else $error("pin edge not flagged after sync delay");

  apb_wait_a: assert property (
    ce_i && apb_req_i.psel && apb_req_i.penable && !pready_o |=> pready_o)
    else $error("pready not raised after one wait");

  apb_pulse_a: assert property (
    ce_i && pready_o |=> !pready_o)
    else $error("pready stood longer than one cycle");

  // port b mirrors port a; its field sits at bits 7:4 of the word
  sequence s_b_clear_wr;
    ce_i && wr_en && hit(apb_req_i.paddr, OFF_B_FLAG);
  endsequence

  rise_sets_b_a: assert property (
    ce_i && (|(b_rise_ev & st_r.b_rise))
    |=> (|(st_r.b_flag & $past(b_rise_ev & st_r.b_rise))))
    else $error("enabled port b rising edge did not set flag");

  fall_sets_b_a: assert property (
    ce_i && (|(b_fall_ev & st_r.b_fall))
    |=> (|(st_r.b_flag & $past(b_fall_ev & st_r.b_fall))))
    else $error("enabled port b falling edge did not set flag");

  sticky_b_a: assert property (
    ce_i && !wr_en |=> ((st_r.b_flag & $past(st_r.b_flag))
                        == $past(st_r.b_flag)))
    else $error("port b flag dropped without a write");

  quiet_b_a: assert property (
    ce_i && !wr_en && b_set == '0 |=> st_r.b_flag == $past(st_r.b_flag))
    else $error("port b flag changed with no edge or write");

  // a flag write stores the data, and any same-cycle edge is or-ed in
  write_a_a: assert property (
    s_a_clear_wr |=> st_r.a_flag
      == ($past(apb_req_i.pwdata[PA_W-1:0]) | $past(a_set)))
    else $error("port a flag write gave a wrong value");

  write_b_a: assert property (
    s_b_clear_wr |=> st_r.b_flag
      == ($past(apb_req_i.pwdata[PB_LSB+PB_W-1:PB_LSB]) | $past(b_set)))
    else $error("port b flag write gave a wrong value");

  // the event bit must follow every flag set, or irq would miss it
  ev_follows_a: assert property (
    ce_i && (|a_set) |=> st_r.ev_sts[EV_A_BIT])
    else $error("port a flag set without an event");

  ev_follows_b_a: assert property (
    ce_i && (|b_set) |=> st_r.ev_sts[EV_B_BIT])
    else $error("port b flag set without an event");

  ev_clear_a: assert property (
    ce_i && wr_en && hit(apb_req_i.paddr, OFF_EV_STS)
    && a_set == '0 && b_set == '0
    |=> (st_r.ev_sts & $past(apb_req_i.pwdata[EV_W-1:0])) == '0)
    else $error("event status one not cleared");

  irq_raise_a: assert property (
    ce_i && st_nxt.ien && (|(st_nxt.ev_sts & st_nxt.ev_msk)) |=> irq_o)
    else $error("unmasked event with master enable gave no interrupt");

  idle_off_a: assert property (
    ce_i && !st_nxt.ien |=> !irq_o && !wake_o)
    else $error("interrupt or wake with master enable off");

  // the flag must already hold when wake rises, never after it
  wake_flag_a: assert property (
    ce_i && st_nxt.ien && (|a_set) |=> wake_o && (|st_r.a_flag))
    else $error("wake without an updated flag");

  ctrl_read_a: assert property (
    ce_i && st_nxt.pready && !apb_req_i.pwrite
    && hit(apb_req_i.paddr, OFF_CTRL)
    |=> prdata_o[CTRL_SUM_BIT] == $past(st_r.summary))
    else $error("summary bit read differs from the flags");

  a_hi_zero_a: assert property (
    ce_i && st_nxt.pready && !apb_req_i.pwrite
    && (hit(apb_req_i.paddr, OFF_A_RISE) || hit(apb_req_i.paddr, OFF_A_FALL))
    |=> prdata_o[PB_LSB+PB_W-1:PA_W] == '0)
    else $error("port a high bits read nonzero");

  err_zero_a: assert property (
    pready_o && pslverr_o |-> prdata_o == '0)
    else $error("refused transfer returned data");

  // a low enable must hold every field, the bus answer included
  ce_hold_a: assert property (
    !ce_i |=> $stable(st_r))
    else $error("state moved while the clock enable was low");

  // prev follows s2, so one pin cannot show two rises in a row
  rise_once_a: assert property (
    ce_i && (|a_rise_ev) |=> !(|(a_rise_ev & $past(a_rise_ev))))
    else $error("one transition flagged twice");

  rise_once_b_a: assert property (
    ce_i && (|b_rise_ev) |=> !(|(b_rise_ev & $past(b_rise_ev))))
    else $error("one port b transition flagged twice");

endmodule // pce_top
